//--- verilog/afpc_dev.sv
// Converter output formatting, output disable and power mode control
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module afpc_dev import afpc_pkg::*; (
  input  wire logic                    i_clk,
  input  wire logic                    i_reset_n,
  input  wire logic signed [RAW_W-1:0] i_raw_ch1,
  input  wire logic signed [RAW_W-1:0] i_raw_ch2,
  input  wire logic                    i_cfg_wr,
  input  wire logic                    i_cfg_rd,
  input  wire logic [2:0]              i_cfg_addr,
  input  wire logic [7:0]              i_cfg_wdata,
  output var  logic [7:0]              o_cfg_rdata,
  input  wire logic                    i_program_mode_strap,
  input  wire logic                    i_cs_pin,
  input  wire logic                    i_sck_pin,
  input  wire logic                    i_sdi_pin,
  input  wire logic                    i_sdo_pin,
  afpc_link_if.dev                     link,
  output var  logic                    o_dcs_enable,
  output var  logic                    o_lvds_mode,
  output var  logic                    o_ch1_nap,
  output var  logic                    o_ch2_nap,
  output var  logic                    o_sleep,
  output var  logic                    o_test_active
);
  // ==========================================================================
  // Static pin synchronisers
  logic [4:0] pin_raw;
  logic [4:0] pin_meta_r;
  logic [4:0] pin_sync_r;
  logic       par_mode;

  assign pin_raw = {i_program_mode_strap, i_cs_pin, i_sck_pin, i_sdi_pin, i_sdo_pin};

  // Pins may be driven by foreign logic, so two stages per pin
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_pin_sync
      always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
          pin_meta_r[gi] <= 1'b0;
          pin_sync_r[gi] <= 1'b0;
        end else begin
          pin_meta_r[gi] <= pin_raw[gi];
          pin_sync_r[gi] <= pin_meta_r[gi];
        end
      end
    end
  endgenerate

  assign par_mode = pin_sync_r[4];

  // ==========================================================================
  // Mode registers written through the strobed register port
  logic [7:0] pwr_r;
  logic [7:0] tim_r;
  logic [7:0] out_r;
  logic [7:0] fmt_r;

  // All modes clear at reset, so coding starts as offset binary
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      pwr_r <= CFG_RST;
      tim_r <= CFG_RST;
      out_r <= CFG_RST;
      fmt_r <= CFG_RST;
    end else if (i_cfg_wr) begin
      case (i_cfg_addr)
        ADDR_PWR: pwr_r <= i_cfg_wdata;
        ADDR_TIM: tim_r <= i_cfg_wdata;
        ADDR_OUT: out_r <= i_cfg_wdata;
        ADDR_FMT: fmt_r <= i_cfg_wdata;
        default:  ;
      endcase
    end
  end

  // Readback one cycle after the strobe, unmapped reads as zero
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_cfg_rdata <= CFG_RST;
    end else if (i_cfg_rd) begin
      case (i_cfg_addr)
        ADDR_PWR: o_cfg_rdata <= pwr_r;
        ADDR_TIM: o_cfg_rdata <= tim_r;
        ADDR_OUT: o_cfg_rdata <= out_r;
        ADDR_FMT: o_cfg_rdata <= fmt_r;
        default:  o_cfg_rdata <= CFG_RST;
      endcase
    end
  end

  // ==========================================================================
  // Effective settings, pins override registers in parallel mode
  logic      twos_eff;
  logic      rand_eff;
  logic      alt_eff;
  logic      dis_eff;
  logic      lvds_eff;
  logic      dcs_eff;
  afpc_tp_t  tp_eff;
  afpc_pwr_t pwr_eff;

  // Parallel mode cannot reach formatting options, they stay off
  always_comb begin
    if (par_mode) begin
      twos_eff = 1'b0;
      rand_eff = 1'b0;
      alt_eff  = 1'b0;
      tp_eff   = TP_OFF;
      dis_eff  = 1'b0;
      dcs_eff  = pin_sync_r[3];
      lvds_eff = pin_sync_r[2];
      pwr_eff  = afpc_pwr_t'(pin_sync_r[1:0]);
    end else begin
      twos_eff = fmt_r[FMT_TWOS];
      rand_eff = fmt_r[FMT_RAND];
      alt_eff  = fmt_r[FMT_ALT];
      tp_eff   = afpc_tp_t'(fmt_r[FMT_TP_HI:FMT_TP_LO]);
      dis_eff  = out_r[OUT_DIS];
      dcs_eff  = tim_r[TIM_DCS];
      lvds_eff = out_r[OUT_LVDS];
      pwr_eff  = afpc_pwr_t'(pwr_r[1:0]);
    end
  end

  // ==========================================================================
  // Power decode, no code naps channel 1 alone
  logic nap1_nxt;
  logic nap2_nxt;
  logic sleep_nxt;

  always_comb begin
    nap1_nxt  = 1'b0;
    nap2_nxt  = 1'b0;
    sleep_nxt = 1'b0;
    case (pwr_eff)
      PWR_RUN:   ;
      PWR_NAP2:  nap2_nxt = 1'b1;
      PWR_NAP12: begin
        nap1_nxt = 1'b1;
        nap2_nxt = 1'b1;
      end
      PWR_SLEEP: sleep_nxt = 1'b1;
      default:   ;
    endcase
  end

  // Mode outputs registered for clean pins
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_ch1_nap     <= 1'b0;
      o_ch2_nap     <= 1'b0;
      o_sleep       <= 1'b0;
      o_dcs_enable  <= 1'b0;
      o_lvds_mode   <= 1'b0;
      o_test_active <= 1'b0;
    end else begin
      o_ch1_nap     <= nap1_nxt;
      o_ch2_nap     <= nap2_nxt;
      o_sleep       <= sleep_nxt;
      o_dcs_enable  <= dcs_eff;
      o_lvds_mode   <= lvds_eff;
      o_test_active <= (tp_eff != TP_OFF);
    end
  end

  // ==========================================================================
  // Sample clock divider and pattern phase
  logic [2:0] div_cnt_r;
  logic       clk_out_r;
  logic       phase_r;
  logic       smp_stb;

  // Data updates on the falling edge, receiver latches on the rising one
  assign smp_stb = (div_cnt_r == DIV_HALF);

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      div_cnt_r <= 3'h0;
      clk_out_r <= 1'b1;
    end else begin
      div_cnt_r <= div_cnt_r + 3'h1;
      if (smp_stb) begin
        clk_out_r <= 1'b0;
      end else if (div_cnt_r == DIV_LAST) begin
        clk_out_r <= 1'b1;
      end
    end
  end

  // Phase flips every sample for the alternating patterns
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      phase_r <= 1'b0;
    end else if (smp_stb) begin
      phase_r <= ~phase_r;
    end
  end

  // ==========================================================================
  // Output enables, the whole bus floats together
  logic oe_r;

  // Slow by design: changes only with the mode, not for bus sharing
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      oe_r <= 1'b1;
    end else begin
      oe_r <= ~dis_eff;
    end
  end

  // ==========================================================================
  // Channel formatters, a napped or sleeping channel holds its last word
  logic [SMP_W-1:0] bits1;
  logic [SMP_W-1:0] bits2;
  logic             ovf1;
  logic             ovf2;

  afpc_chan_fmt u_fmt1 (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_load    (smp_stb),
    .i_hold    (o_ch1_nap | o_sleep),
    .i_raw     (i_raw_ch1),
    .i_twos    (twos_eff),
    .i_rand    (rand_eff),
    .i_alt     (alt_eff),
    .i_tp      (tp_eff),
    .i_phase   (phase_r),
    .o_bits    (bits1),
    .o_ovf     (ovf1)
  );

  afpc_chan_fmt u_fmt2 (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_load    (smp_stb),
    .i_hold    (o_ch2_nap | o_sleep),
    .i_raw     (i_raw_ch2),
    .i_twos    (twos_eff),
    .i_rand    (rand_eff),
    .i_alt     (alt_eff),
    .i_tp      (tp_eff),
    .i_phase   (phase_r),
    .o_bits    (bits2),
    .o_ovf     (ovf2)
  );

  // Link pins, all from flip-flops
  assign link.output_data_clock = clk_out_r;
  assign link.clock_oe          = oe_r;
  assign link.data_oe           = oe_r;
  assign link.sample_bits_ch1   = bits1;
  assign link.sample_bits_ch2   = bits2;
  assign link.overflow_flag     = {ovf2, ovf1};
endmodule : afpc_dev
`default_nettype wire

//--- pkg/afpc_pkg.sv
// Shared constants and types of the output formatting and power control block
package afpc_pkg;
  // ==========================================================================
  // Sample coding
  localparam int                 SMP_W      = 14;
  localparam int                 RAW_W      = 16;
  localparam logic signed [15:0] POS_FS     = 16'sh1FFF;
  localparam logic signed [15:0] NEG_FS     = 16'shE000;
  localparam logic [13:0]        MSB_MASK   = 14'h2000;
  localparam logic [13:0]        POS_CODE   = 14'h3FFF;
  localparam logic [13:0]        NEG_CODE   = 14'h0000;
  localparam logic [13:0]        ODD_MASK   = 14'h2AAA;
  localparam logic [14:0]        PAT_ONES   = 15'h7FFF;
  localparam logic [14:0]        PAT_ZEROS  = 15'h0000;
  localparam logic [14:0]        PAT_CHK_A  = 15'h5555;
  localparam logic [14:0]        PAT_CHK_B  = 15'h2AAA;

  // ==========================================================================
  // Sample clock divider (8 system cycles per sample)
  localparam logic [2:0] DIV_LAST   = 3'h7;
  localparam logic [2:0] DIV_HALF   = 3'h3;

  // ==========================================================================
  // Device mode registers
  localparam logic [2:0] ADDR_PWR   = 3'h1;
  localparam logic [2:0] ADDR_TIM   = 3'h2;
  localparam logic [2:0] ADDR_OUT   = 3'h3;
  localparam logic [2:0] ADDR_FMT   = 3'h4;
  localparam logic [7:0] CFG_RST    = 8'h00;
  localparam int         FMT_TWOS   = 0;
  localparam int         FMT_RAND   = 1;
  localparam int         FMT_ALT    = 2;
  localparam int         FMT_TP_LO  = 3;
  localparam int         FMT_TP_HI  = 5;
  localparam int         OUT_DIS    = 0;
  localparam int         OUT_LVDS   = 1;
  localparam int         TIM_DCS    = 0;

  typedef enum logic [2:0] {
    TP_OFF   = 3'h0,
    TP_ONES  = 3'h1,
    TP_ZEROS = 3'h2,
    TP_ALT   = 3'h3,
    TP_CHK   = 3'h4
  } afpc_tp_t;

  typedef enum logic [1:0] {
    PWR_RUN   = 2'h0,
    PWR_NAP2  = 2'h1,
    PWR_NAP12 = 2'h2,
    PWR_SLEEP = 2'h3
  } afpc_pwr_t;

  // ==========================================================================
  // Receiver timing
  localparam int         CLK_HZ         = 10_000_000;
  localparam int         SLEEP_WAKE_MS  = 2;
  localparam int         SLEEP_WAKE_CYC = (SLEEP_WAKE_MS * CLK_HZ + 999) / 1000;
  localparam int         DC_SETTLE_US   = 50;
  localparam int         DC_SETTLE_CYC  = (DC_SETTLE_US * CLK_HZ + 999_999) / 1_000_000;
  localparam logic [7:0] NAP_DISCARD    = 8'h64;

  // ==========================================================================
  // Receiver registers
  localparam logic [2:0] H_CTRL     = 3'h0;
  localparam logic [2:0] H_WAKE     = 3'h1;
  localparam logic [2:0] H_STAT     = 3'h2;
  localparam logic [2:0] H_DATA1    = 3'h3;
  localparam logic [2:0] H_DATA2    = 3'h4;
  localparam int         CTRL_RAND  = 0;
  localparam int         CTRL_ALT   = 1;
  localparam int         WAKE_SLEEP = 0;
  localparam int         WAKE_NAP   = 1;
  localparam int         WAKE_DC    = 2;

  typedef enum logic [2:0] {
    HS_IDLE    = 3'b001,
    HS_DISCARD = 3'b010,
    HS_SETTLE  = 3'b100
  } afpc_hst_t;
endpackage : afpc_pkg

//--- pkg/afpc_link_if.sv
// Link between the converter output side and the capture receiver
`timescale 1ns/100ps
`default_nettype none
interface afpc_link_if;
  logic        output_data_clock;
  logic        clock_oe;
  logic        data_oe;
  logic [13:0] sample_bits_ch1;
  logic [13:0] sample_bits_ch2;
  logic [1:0]  overflow_flag;

  modport dev (
    output output_data_clock,
    output clock_oe,
    output data_oe,
    output sample_bits_ch1,
    output sample_bits_ch2,
    output overflow_flag
  );
  modport rcv (
    input  output_data_clock,
    input  clock_oe,
    input  data_oe,
    input  sample_bits_ch1,
    input  sample_bits_ch2,
    input  overflow_flag
  );
endinterface : afpc_link_if
`default_nettype wire

//--- verilog/afpc_chan_fmt.sv
// One channel of sample coding, scrambling and test pattern selection
`timescale 1ns/100ps
`default_nettype none
module afpc_chan_fmt import afpc_pkg::*; (
  input  wire logic                    i_clk,
  input  wire logic                    i_reset_n,
  input  wire logic                    i_load,
  input  wire logic                    i_hold,
  input  wire logic signed [RAW_W-1:0] i_raw,
  input  wire logic                    i_twos,
  input  wire logic                    i_rand,
  input  wire logic                    i_alt,
  input  wire afpc_tp_t                i_tp,
  input  wire logic                    i_phase,
  output var  logic [SMP_W-1:0]        o_bits,
  output var  logic                    o_ovf
);
  // ==========================================================================
  // Formatting chain
  logic             ovf;
  logic [SMP_W-1:0] code;
  logic [SMP_W-1:0] wrd;
  logic [14:0]      outw;

  // Coding, then randomizer, then alternate polarity, then pattern override
  always_comb begin
    ovf  = (i_raw > POS_FS) || (i_raw <= NEG_FS);
    if (i_raw > POS_FS) begin
      code = POS_CODE;
    end else if (i_raw <= NEG_FS) begin
      code = NEG_CODE;
    end else begin
      code = i_raw[SMP_W-1:0] ^ MSB_MASK;
    end
    wrd = i_twos ? (code ^ MSB_MASK) : code;
    if (i_rand) begin
      wrd[SMP_W-1:1] = wrd[SMP_W-1:1] ^ {(SMP_W-1){wrd[0]}};
    end
    if (i_alt) begin
      wrd = wrd ^ ODD_MASK;
    end
    // Patterns bypass every formatting option
    case (i_tp)
      TP_ONES:  outw = PAT_ONES;
      TP_ZEROS: outw = PAT_ZEROS;
      TP_ALT:   outw = i_phase ? PAT_ZEROS : PAT_ONES;
      TP_CHK:   outw = i_phase ? PAT_CHK_B : PAT_CHK_A;
      default:  outw = {ovf, wrd};
    endcase
  end

  // One register stage so flag and data keep the same latency
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_bits <= MSB_MASK;
      o_ovf  <= 1'b0;
    end else if (i_load && !i_hold) begin
      o_bits <= outw[SMP_W-1:0];
      o_ovf  <= outw[SMP_W];
    end
  end
endmodule : afpc_chan_fmt
`default_nettype wire

//--- verilog/afpc_rcv.sv
// Capture receiver: samples the link, undoes scrambling, wake hold-off
`timescale 1ns/100ps
`default_nettype none
module afpc_rcv import afpc_pkg::*; #(
  parameter int P_SLEEP_WAKE_CYC = SLEEP_WAKE_CYC
) (
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  afpc_link_if.rcv              link,
  input  wire logic [2:0]       i_addr,
  input  wire logic [15:0]      i_wdata,
  input  wire logic             i_wr,
  input  wire logic             i_rd,
  output var  logic [15:0]      o_rdata,
  output var  logic [SMP_W-1:0] o_ch1_word,
  output var  logic [SMP_W-1:0] o_ch2_word,
  output var  logic [1:0]       o_ovf,
  output var  logic             o_valid,
  output var  logic             o_holdoff
);
  // ==========================================================================
  // Link synchronisers, clock and data delayed alike
  localparam int LW = 33;
  // Link clock idles high after reset, so the edge detector starts high too
  localparam logic [LW-1:0] LNK_IDLE = {1'b1, {(LW-1){1'b0}}};
  logic [LW-1:0] lnk_raw;
  logic [LW-1:0] lnk_meta_r;
  logic [LW-1:0] lnk_sync_r;
  logic          clk_prev_r;
  logic          take;

  assign lnk_raw = {link.output_data_clock, link.clock_oe, link.data_oe,
                    link.overflow_flag, link.sample_bits_ch2, link.sample_bits_ch1};

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      lnk_meta_r <= LNK_IDLE;
      lnk_sync_r <= LNK_IDLE;
      clk_prev_r <= 1'b1;                            // No false capture after reset
    end else begin
      lnk_meta_r <= lnk_raw;
      lnk_sync_r <= lnk_meta_r;
      clk_prev_r <= lnk_sync_r[LW-1];
    end
  end

  // Rising link clock edge while the bus is driven
  assign take = lnk_sync_r[LW-1] & ~clk_prev_r & lnk_sync_r[LW-2] & lnk_sync_r[LW-3];

  // ==========================================================================
  // Control registers
  logic [15:0] ctrl_r;
  logic        wake_wr;

  assign wake_wr = i_wr && (i_addr == H_WAKE);

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      ctrl_r <= 16'h0000;
    end else if (i_wr && (i_addr == H_CTRL)) begin
      ctrl_r <= i_wdata;
    end
  end

  // ==========================================================================
  // Descrambling: polarity first, then the LSB XOR
  function automatic logic [SMP_W-1:0] decode(input logic [SMP_W-1:0] d,
                                               input logic rnd, input logic alt);
    logic [SMP_W-1:0] w;
    w = alt ? (d ^ ODD_MASK) : d;
    if (rnd) begin
      w[SMP_W-1:1] = w[SMP_W-1:1] ^ {(SMP_W-1){w[0]}};
    end
    return w;
  endfunction : decode

  // ==========================================================================
  // Wake hold-off
  afpc_hst_t   st_r;
  logic [14:0] cyc_cnt_r;
  logic [7:0]  smp_cnt_r;
  logic        dc_r;

  // Sleep waits on time; nap discards samples, then optional settling
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st_r      <= HS_IDLE;
      cyc_cnt_r <= 15'h0000;
      smp_cnt_r <= 8'h00;
      dc_r      <= 1'b0;
    end else if (wake_wr && i_wdata[WAKE_SLEEP]) begin
      st_r      <= HS_SETTLE;
      cyc_cnt_r <= 15'(P_SLEEP_WAKE_CYC);
    end else if (wake_wr && i_wdata[WAKE_NAP]) begin
      st_r      <= HS_DISCARD;
      smp_cnt_r <= NAP_DISCARD;
      dc_r      <= i_wdata[WAKE_DC];
    end else begin
      case (st_r)
        HS_IDLE: ;
        HS_DISCARD: begin
          if (take) begin
            smp_cnt_r <= smp_cnt_r - 8'h01;
            if (smp_cnt_r == 8'h01) begin
              st_r      <= dc_r ? HS_SETTLE : HS_IDLE;
              cyc_cnt_r <= 15'(DC_SETTLE_CYC);
            end
          end
        end
        HS_SETTLE: begin
          cyc_cnt_r <= cyc_cnt_r - 15'h0001;
          if (cyc_cnt_r <= 15'h0001) begin
            st_r <= HS_IDLE;
          end
        end
        default: st_r <= HS_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Captured words, valid only outside the hold-off
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_ch1_word <= MSB_MASK;
      o_ch2_word <= MSB_MASK;
      o_ovf      <= 2'h0;
      o_valid    <= 1'b0;
      o_holdoff  <= 1'b0;
    end else begin
      o_valid   <= take && (st_r == HS_IDLE);
      o_holdoff <= (st_r != HS_IDLE);
      if (take) begin
        o_ch1_word <= decode(lnk_sync_r[13:0], ctrl_r[CTRL_RAND], ctrl_r[CTRL_ALT]);
        o_ch2_word <= decode(lnk_sync_r[27:14], ctrl_r[CTRL_RAND], ctrl_r[CTRL_ALT]);
        o_ovf      <= lnk_sync_r[29:28];
      end
    end
  end

  // Readback one cycle after the strobe; status bit 1 flags floated outputs
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      case (i_addr)
        H_CTRL:  o_rdata <= ctrl_r;
        H_STAT:  o_rdata <= {12'h000, o_ovf, ~lnk_sync_r[LW-3], o_holdoff};
        H_DATA1: o_rdata <= {2'h0, o_ch1_word};
        H_DATA2: o_rdata <= {2'h0, o_ch2_word};
        default: o_rdata <= 16'h0000;
      endcase
    end
  end
endmodule : afpc_rcv
`default_nettype wire

//--- dv/afpc_asserts.sv
// Timing and framing checks on the converter output link
`timescale 1ns/100ps
`default_nettype none
module afpc_asserts (
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic        output_data_clock,
  input wire logic        clock_oe,
  input wire logic        data_oe,
  input wire logic [13:0] sample_bits_ch1,
  input wire logic [13:0] sample_bits_ch2,
  input wire logic [1:0]  overflow_flag
);
  // ==================================================
  // Link clock shape, launch edge and enables
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  clk_high_a: assert property (
    $rose(output_data_clock) |-> output_data_clock[*4] ##1 !output_data_clock)
    else $error("link clock high phase wrong");
  clk_period_a: assert property (
    $fell(output_data_clock) |-> ##8 $fell(output_data_clock))
    else $error("link clock period wrong");
  ch1_edge_a: assert property (
    $changed(sample_bits_ch1) |-> $fell(output_data_clock))
    else $error("channel 1 word moved off the falling edge");
  ch2_edge_a: assert property (
    $changed(sample_bits_ch2) |-> $fell(output_data_clock))
    else $error("channel 2 word moved off the falling edge");
  ovf_edge_a: assert property (
    $changed(overflow_flag) |-> $fell(output_data_clock))
    else $error("overflow flag moved off the word edge");
  word_hold_a: assert property (
    $fell(output_data_clock) |=> ($stable(sample_bits_ch2))[*7])
    else $error("channel 2 word did not stand a full sample");
  // Channel 2 flag only with an offset binary full scale code or a forced pattern
  ovf_code_a: assert property (
    overflow_flag[1] |-> sample_bits_ch2 inside {14'h3FFF, 14'h0000, 14'h1555})
    else $error("overflow flag without a full scale code");
  oe_pair_a: assert property (clock_oe == data_oe)
    else $error("clock and data enables disagree");
endmodule : afpc_asserts
`default_nettype wire

//--- dv/adc_output_format_power_ctrl_test.sv
// Bench joining the converter end and the receiver end of the link
`timescale 1ns/100ps
`default_nettype none
module adc_output_format_power_ctrl_test import afpc_pkg::*;;
  // ==================================================
  // Stimulus, notes and instances
  logic               i_clk = 0, i_reset_n = 0, cw = 0, cr = 0, hw = 0, hr = 0;
  logic signed [15:0] raw1 = 0, raw2 = 0;
  logic [2:0]         ca = 0, ha = 0, pw [4];
  logic [15:0]        hd = 0, q;
  logic [7:0]         cd = 0;
  logic [4:0]         pin = 0;
  logic [14:0]        a, b, pp [4], pq [4];
  logic [29:0]        notes[$];
  wire logic [7:0]    crd;
  wire logic [15:0]   hrd;
  wire logic [13:0]   w1, w2;
  wire logic [1:0]    ov;
  wire logic          vld, hold, dcs, lvds, n1, n2, slp, tst;
  int                 fails = 0, checks_done = 0, seed = 4, k, n, lo;
  afpc_link_if link ();
  afpc_dev i_afpc_dev (.i_clk, .i_reset_n, .i_raw_ch1(raw1), .i_raw_ch2(raw2),
    .i_cfg_wr(cw), .i_cfg_rd(cr), .i_cfg_addr(ca), .i_cfg_wdata(cd), .o_cfg_rdata(crd),
    .i_program_mode_strap(pin[4]), .i_cs_pin(pin[3]), .i_sck_pin(pin[2]),
    .i_sdi_pin(pin[1]), .i_sdo_pin(pin[0]), .link(link.dev), .o_dcs_enable(dcs),
    .o_lvds_mode(lvds), .o_ch1_nap(n1), .o_ch2_nap(n2), .o_sleep(slp), .o_test_active(tst));
  afpc_rcv #(.P_SLEEP_WAKE_CYC(50)) i_afpc_rcv (.i_clk, .i_reset_n, .link(link.rcv),
    .i_addr(ha), .i_wdata(hd), .i_wr(hw), .i_rd(hr), .o_rdata(hrd), .o_ch1_word(w1),
    .o_ch2_word(w2), .o_ovf(ov), .o_valid(vld), .o_holdoff(hold));
  afpc_asserts i_afpc_asserts (.i_clk, .i_reset_n, .clock_oe(link.clock_oe),
    .output_data_clock(link.output_data_clock), .data_oe(link.data_oe),
    .sample_bits_ch1(link.sample_bits_ch1), .sample_bits_ch2(link.sample_bits_ch2),
    .overflow_flag(link.overflow_flag));
  always #50 i_clk = ~i_clk;
  // Oldest note against each delivered sample
  always @(negedge i_clk) if (vld === 1'b1 && notes.size() > 0)
    check({ov, w1, w2}, notes.pop_front());
  task automatic check(input logic [29:0] s, e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("Error at %0t: saw %h, want %h", $time, s, e);
    end
  endtask : check
  task automatic results;
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  // One strobe cycle on either port; read data taken the cycle after
  task automatic bus(input bit dev, wr, input logic [2:0] ad, input logic [15:0] d);
    @(posedge i_clk);
    {cw, cr, hw, hr} <= dev ? {wr, !wr, 2'b00} : {2'b00, wr, !wr};
    {ca, ha, cd, hd} <= {ad, ad, d[7:0], d};
    @(posedge i_clk);
    {cw, cr, hw, hr} <= 4'h0;
    @(posedge i_clk);
    q = dev ? {8'h00, crd} : hrd;
  endtask : bus
  // Expected word: coding, then scrambling, then odd bit inversion
  function automatic logic [13:0] code(input logic signed [15:0] r, input logic [2:0] f);
    logic [13:0] w;
    w = r > POS_FS ? POS_CODE : r <= NEG_FS ? NEG_CODE : 14'(r + 16'sh2000);
    if (f[0]) w ^= MSB_MASK;
    if (f[1]) w ^= {{13{w[0]}}, 1'b0};
    if (f[2]) w ^= ODD_MASK;
    return w;
  endfunction : code
  task automatic run(input logic signed [15:0] r1, r2, input logic [2:0] f, input logic [1:0] u);
    bus(1, 1, ADDR_FMT, {13'h0, f});
    bus(0, 1, H_CTRL, {14'h0, u});
    {raw1, raw2} <= {r1, r2};
    repeat (40) @(posedge i_clk);
    f = f & ~{u, 1'b0};
    notes.push_back({r2 > POS_FS || r2 <= NEG_FS, r1 > POS_FS || r1 <= NEG_FS,
      code(r1, f), code(r2, f)});
    for (k = 0; k < 40 && notes.size() > 0; k++) @(posedge i_clk);
    if (k == 40) begin
      fails++;
      results();
    end
  endtask : run
  // Next delivered channel 1 sample with its flag; bounded wait
  task automatic getw(output logic [14:0] v);
    k = 0;
    do @(negedge i_clk); while (vld !== 1'b1 && ++k < 40);
    if (k == 40) begin
      fails++;
      results();
    end
    v = {ov[0], w1};
  endtask : getw
  initial begin
    pp = '{PAT_ONES, PAT_ZEROS, PAT_ONES, PAT_CHK_A};
    pq = '{PAT_ONES, PAT_ZEROS, PAT_ZEROS, PAT_CHK_B};
    pw = '{3'h0, 3'h2, 3'h6, 3'h1};
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1;
    bus(1, 0, ADDR_FMT, 0);
    check(q, 0);
    bus(1, 0, 3'h7, 0);
    check(q, 0);
    run(0, POS_FS, 0, 0);
    run(POS_FS + 16'sh1, NEG_FS, 0, 0);
    for (int f = 0; f < 9; f++) run(16'($random(seed) % 8192), 16'($random(seed) % 8192),
      f < 8 ? 3'(f) : 3'h6, f < 8 ? 2'(f >> 1) : 2'h0);
    $display("Done coding");
    for (int m = 0; m < 4; m++) begin
      bus(1, 1, ADDR_FMT, {10'h0, 3'(m + 1), 3'h7});
      repeat (40) @(posedge i_clk);
      getw(a);
      getw(b);
      check({a, b}, (a === pp[m]) ? {pp[m], pq[m]} : {pq[m], pp[m]});
      check(tst, 1);
    end
    bus(1, 1, ADDR_FMT, 0);
    $display("Done patterns");
    for (int c = 0; c < 4; c++) begin
      bus(1, 1, ADDR_PWR, 16'(c));
      repeat (2) @(posedge i_clk);
      check({n1 & ~slp, n2 & ~slp, slp}, pw[c]);
    end
    // Register path for stabilizer and output mode
    bus(1, 1, ADDR_TIM, 1);
    bus(1, 1, ADDR_OUT, 2);
    repeat (2) @(posedge i_clk);
    check({dcs, lvds}, 2'h3);
    // Outputs floated while asleep, as advised for long idle spells
    bus(1, 1, ADDR_OUT, 1);
    repeat (2) @(posedge i_clk);
    check({link.data_oe, link.clock_oe}, 0);
    bus(0, 0, H_STAT, 0);
    check(q[1], 1);
    bus(1, 1, ADDR_OUT, 0);
    bus(1, 1, ADDR_PWR, 0);
    $display("Done power");
    // Sleep wake, nap wake, then nap wake with the DC settling tail
    for (int i = 0; i < 3; i++) begin
      bus(0, 1, H_WAKE, 16'(i == 0 ? 1 : i == 1 ? 2 : 6));
      @(posedge i_clk);                              // Hold-off flag lags the write
      for (n = 0; n < 2000 && hold === 1'b1; n++) @(posedge i_clk);
      lo = i ? 8 * NAP_DISCARD - 16 + (i - 1) * DC_SETTLE_CYC : 45;
      check(n >= lo && n <= lo + (i ? 24 : 5), 1);
      if (n == 2000) results();
    end
    $display("Done wake");
    for (int i = 0; i < 4; i++) begin
      pin <= {1'b1, 2'($random(seed)), 2'(i)};
      repeat (6) @(posedge i_clk);
      check({dcs, lvds, n1 & ~slp, n2 & ~slp, slp}, {pin[3:2], pw[i]});
    end
    $display("Done parallel");
    results();
  end
endmodule : adc_output_format_power_ctrl_test
`default_nettype wire
